// ==== fifo_tx_rx_config_control.sv ====
/*
 * FIFO receive/transmit configuration control: an APB slave holding the
 * receive and transmit configuration registers, the FIFO flush pulses,
 * receive offset and end-alignment padding, and transmitter start/stop.
 * Assumes the FIFO, receive and transmit engines run on CLOCK, so their
 * strobes and flags arrive synchronous and are read without synchronisers.
 */
// Decided for this implementation: the APB register port.
// Functional notes
// - Receive flush empties receive data and status FIFOs
// - Five-bit receive byte offset, reset zero
// - Word offset bits take effect next word read
// - End alignment codes: 4, 16, 32 bytes
// - Status flush empties transmit status FIFO
// - Data flush empties transmit data FIFO
// - Full status FIFO suspends unless overrun allowed
// - Overrun permission never affects full interrupt event
// - Transmitter enable bit starts queued transmission
// - Enable clears itself after stop and halt
// - Stop request finishes frame, then self-clears
// - Writes to stop ignored while it is high
// - Filler words pad last transfer to alignment
`timescale 1ns/1ps
`default_nettype none

module fifo_tx_rx_config_control
    import fifo_cfg_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    // Clock and reset.
    input  wire logic              CLOCK,
    input  wire logic              RSTN,
    // APB slave.
    input  wire logic              PSEL,
    input  wire logic              PENABLE,
    input  wire logic              PWRITE,
    input  wire logic [ADDR_W-1:0] PADDR,
    input  wire logic [31:0]       PWDATA,
    output logic [31:0]            PRDATA,
    output logic                   PREADY,
    output logic                   PSLVERR,
    // Engine status and strobes.
    input  wire logic              TX_HALTED,
    input  wire logic              TX_STATUS_FULL,
    input  wire logic              RX_WORD_READ,
    input  wire logic              RX_PKT_START,
    input  wire logic              RX_LAST_READ,
    // FIFO pointer clears.
    output logic                   RX_FIFO_CLEAR,
    output logic                   TXS_FIFO_CLEAR,
    output logic                   TXD_FIFO_CLEAR,
    // Receive data shaping.
    output logic [1:0]             RX_BYTE_OFFSET,
    output logic [2:0]             RX_WORD_OFFSET,
    output logic [1:0]             RX_END_ALIGN,
    output logic [2:0]             RX_PAD_WORDS,
    output logic                   RX_PAD_VALID,
    // Transmit control.
    output logic                   TX_ENABLE,
    output logic                   TX_STOP_REQ,
    output logic                   TX_SUSPEND,
    output logic                   TSF_FULL_EVT
);

    rx_cfg_t     rx_r;
    tx_cfg_t     tx_r;
    logic        pready_r;
    logic [31:0] prdata_r;
    logic        pslverr_r;
    logic [2:0]  word_off_r;
    logic [2:0]  word_cnt_r;
    logic [2:0]  pad_r;
    logic        pad_valid_r;
    logic        suspend_r;
    logic        full_evt_r;

    logic        setup;
    logic        wr_en;
    logic        wr_rx;
    logic        wr_tx;
    logic        hit_rx;
    logic        hit_tx;
    logic        stop_done;
    logic [31:0] rd_nxt;
    logic [2:0]  pad_mask;
    logic [2:0]  pad_nxt;

    // Address decode; only the low byte of the address selects a register.
    assign hit_rx    = (PADDR[7:0] == RX_CFG_ADDR);
    assign hit_tx    = (PADDR[7:0] == TX_CFG_ADDR);
    assign setup     = PSEL & ~PENABLE;
    assign wr_en     = PSEL & PENABLE & PWRITE & pready_r;
    assign wr_rx     = wr_en & hit_rx;
    assign wr_tx     = wr_en & hit_tx;
    assign stop_done = tx_r.stop_req & TX_HALTED;

    // Read mux; reserved bits and the out-of-scope DMA count read zero.
    always_comb begin
        rd_nxt = 32'h0000_0000;
        if (hit_rx) begin
            rd_nxt[RX_ALIGN_HI:RX_ALIGN_LO] = rx_r.align;
            rd_nxt[RX_FLUSH_BIT]            = rx_r.flush;
            rd_nxt[RX_OFF_HI:RX_OFF_LO]     = rx_r.byte_offset;
        end else if (hit_tx) begin
            rd_nxt[TXS_FLUSH_BIT] = tx_r.status_flush;
            rd_nxt[TXD_FLUSH_BIT] = tx_r.data_flush;
            rd_nxt[TX_ALLOW_BIT]  = tx_r.allow_overrun;
            rd_nxt[TX_ON_BIT]     = tx_r.tx_on;
            rd_nxt[TX_STOP_BIT]   = tx_r.stop_req;
        end
    end

    // APB handshake: one fixed wait-free access phase after every setup.
    // Read data and error are sampled at setup so the outputs are registered.
    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            pready_r  <= 1'b0;
            prdata_r  <= 32'h0000_0000;
            pslverr_r <= 1'b0;
        end else begin
            pready_r  <= setup;
            pslverr_r <= setup & ~(hit_rx | hit_tx);
            if (setup) begin
                prdata_r <= rd_nxt;
            end
        end
    end

    // Receive configuration; flush is a one-cycle self-clearing bit.
    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            rx_r.align       <= RX_ALIGN_RST;
            rx_r.flush       <= 1'b0;
            rx_r.byte_offset <= RX_OFF_RST;
        end else begin
            rx_r.flush <= wr_rx & PWDATA[RX_FLUSH_BIT];
            if (wr_rx) begin
                rx_r.align       <= PWDATA[RX_ALIGN_HI:RX_ALIGN_LO];
                rx_r.byte_offset <= PWDATA[RX_OFF_HI:RX_OFF_LO];
            end
        end
    end

    // The word part of the offset is only picked up at a word read, so a
    // change while the receiver runs never splits a word in flight.
    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            word_off_r <= 3'h0;
        end else if (RX_WORD_READ) begin
            word_off_r <= rx_r.byte_offset[4:2];
        end
    end

    // Pad mask per alignment; the reserved code falls back to 4-byte.
    always_comb begin
        case (rx_r.align)
            ALIGN_4B:  pad_mask = PAD_MASK_4B;
            ALIGN_16B: pad_mask = PAD_MASK_16B;
            ALIGN_32B: pad_mask = PAD_MASK_32B;
            default:   pad_mask = PAD_MASK_4B;
        endcase
    end

    // Filler words to reach the alignment, counting the last word itself.
    assign pad_nxt = (3'h0 - (word_cnt_r + 3'h1)) & pad_mask;

    // Word counter modulo eight within a buffer, and pad result.
    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            word_cnt_r  <= 3'h0;
            pad_r       <= 3'h0;
            pad_valid_r <= 1'b0;
        end else begin
            pad_valid_r <= RX_LAST_READ;
            if (RX_PKT_START) begin
                word_cnt_r <= 3'h0;
            end else if (RX_WORD_READ) begin
                word_cnt_r <= word_cnt_r + 3'h1;
            end
            if (RX_LAST_READ) begin
                pad_r <= pad_nxt;
            end
        end
    end

    // Transmit flush bits and overrun permission.
    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            tx_r.status_flush  <= 1'b0;
            tx_r.data_flush    <= 1'b0;
            tx_r.allow_overrun <= 1'b0;
        end else begin
            tx_r.status_flush <= wr_tx & PWDATA[TXS_FLUSH_BIT];
            tx_r.data_flush   <= wr_tx & PWDATA[TXD_FLUSH_BIT];
            if (wr_tx) begin
                tx_r.allow_overrun <= PWDATA[TX_ALLOW_BIT];
            end
        end
    end

    // Transmitter enable. A write in the very cycle the halt completes wins,
    // so software restarting the transmitter is never silently undone.
    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            tx_r.tx_on <= 1'b0;
        end else if (wr_tx) begin
            tx_r.tx_on <= PWDATA[TX_ON_BIT];
        end else if (stop_done) begin
            tx_r.tx_on <= 1'b0;
        end
    end

    // Stop request: settable only while low, cleared once halted.
    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            tx_r.stop_req <= 1'b0;
        end else if (tx_r.stop_req) begin
            if (TX_HALTED) begin
                tx_r.stop_req <= 1'b0;
            end
        end else if (wr_tx & PWDATA[TX_STOP_BIT]) begin
            tx_r.stop_req <= 1'b1;
        end
    end

    // Suspend and full event. The full event ignores the permission bit.
    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            suspend_r  <= 1'b0;
            full_evt_r <= 1'b0;
        end else begin
            suspend_r  <= tx_r.tx_on & TX_STATUS_FULL & ~tx_r.allow_overrun;
            full_evt_r <= TX_STATUS_FULL;
        end
    end

    // Output assignments, all straight from flip-flops.
    assign PRDATA         = prdata_r;
    assign PREADY         = pready_r;
    assign PSLVERR        = pslverr_r;
    assign RX_FIFO_CLEAR  = rx_r.flush;
    assign TXS_FIFO_CLEAR = tx_r.status_flush;
    assign TXD_FIFO_CLEAR = tx_r.data_flush;
    assign RX_BYTE_OFFSET = rx_r.byte_offset[1:0];
    assign RX_WORD_OFFSET = word_off_r;
    assign RX_END_ALIGN   = rx_r.align;
    assign RX_PAD_WORDS   = pad_r;
    assign RX_PAD_VALID   = pad_valid_r;
    assign TX_ENABLE      = tx_r.tx_on;
    assign TX_STOP_REQ    = tx_r.stop_req;
    assign TX_SUSPEND     = suspend_r;
    assign TSF_FULL_EVT   = full_evt_r;

    // Checks on the register bank behaviour.
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RSTN);

    property p_rx_flush;
        wr_rx && PWDATA[RX_FLUSH_BIT] |=> RX_FIFO_CLEAR ##1 !RX_FIFO_CLEAR;
    endproperty
    a_rx_flush: assert property (p_rx_flush) else $error("Receive flush pulse wrong.");

    property p_offset;
        wr_rx |=> RX_BYTE_OFFSET == $past(PWDATA[RX_OFF_LO+1:RX_OFF_LO])
            && RX_END_ALIGN == $past(PWDATA[RX_ALIGN_HI:RX_ALIGN_LO]);
    endproperty
    a_offset: assert property (p_offset) else $error("Offset or alignment not stored.");

    property p_word_off;
        RX_WORD_READ |=> RX_WORD_OFFSET == $past(rx_r.byte_offset[4:2]);
    endproperty
    a_word_off: assert property (p_word_off) else $error("Word offset not applied.");

    property p_pad4;
        RX_LAST_READ && rx_r.align == ALIGN_4B |=> RX_PAD_VALID && RX_PAD_WORDS == 3'h0;
    endproperty
    a_pad4: assert property (p_pad4) else $error("Pad for 4-byte alignment wrong.");

    // Words read plus filler must land on a 16-byte line, with less than a line of filler.
    property p_pad16;
        RX_LAST_READ && rx_r.align == ALIGN_16B |=> RX_PAD_VALID && RX_PAD_WORDS <= PAD_MASK_16B
            && ((($past(word_cnt_r) + 3'h1 + RX_PAD_WORDS) & PAD_MASK_16B) == 3'h0);
    endproperty
    a_pad16: assert property (p_pad16) else $error("Pad for 16-byte alignment wrong.");

    property p_pad32;
        RX_LAST_READ && rx_r.align == ALIGN_32B |=> RX_PAD_VALID
            && ((($past(word_cnt_r) + 3'h1 + RX_PAD_WORDS) & PAD_MASK_32B) == 3'h0);
    endproperty
    a_pad32: assert property (p_pad32) else $error("Pad for 32-byte alignment wrong.");

    property p_txs_flush;
        wr_tx && PWDATA[TXS_FLUSH_BIT] |=> TXS_FIFO_CLEAR ##1 !TXS_FIFO_CLEAR;
    endproperty
    a_txs_flush: assert property (p_txs_flush) else $error("Status flush pulse wrong.");

    property p_txd_flush;
        wr_tx && PWDATA[TXD_FLUSH_BIT] |=> TXD_FIFO_CLEAR ##1 !TXD_FIFO_CLEAR;
    endproperty
    a_txd_flush: assert property (p_txd_flush) else $error("Data flush pulse wrong.");

    property p_suspend;
        TX_ENABLE && TX_STATUS_FULL && !tx_r.allow_overrun |=> TX_SUSPEND;
    endproperty
    a_suspend: assert property (p_suspend) else $error("Transmit not suspended.");

    property p_allow;
        tx_r.allow_overrun |=> !TX_SUSPEND;
    endproperty
    a_allow: assert property (p_allow) else $error("Suspended despite overrun permission.");

    property p_full_evt;
        TX_STATUS_FULL |=> TSF_FULL_EVT;
    endproperty
    a_full_evt: assert property (p_full_evt) else $error("Full event missing.");

    property p_enable;
        wr_tx && PWDATA[TX_ON_BIT] |=> TX_ENABLE;
    endproperty
    a_enable: assert property (p_enable) else $error("Transmitter not enabled.");

    property p_halt_clear;
        stop_done && !wr_tx |=> !TX_ENABLE && !TX_STOP_REQ;
    endproperty
    a_halt_clear: assert property (p_halt_clear) else $error("Stop did not clear bits.");

    property p_stop_hold;
        TX_STOP_REQ && !TX_HALTED |=> TX_STOP_REQ;
    endproperty
    a_stop_hold: assert property (p_stop_hold) else $error("Stop request dropped early.");

    property p_stop_set;
        !TX_STOP_REQ && wr_tx && PWDATA[TX_STOP_BIT] |=> TX_STOP_REQ;
    endproperty
    a_stop_set: assert property (p_stop_set) else $error("Stop request not taken.");

    c_stop_seq: cover property (wr_tx && PWDATA[TX_STOP_BIT] ##[1:20] stop_done);
    c_pad32: cover property (RX_LAST_READ && rx_r.align == ALIGN_32B ##1 RX_PAD_WORDS != 3'h0);
    c_suspend: cover property (TX_SUSPEND);
    c_word_off: cover property (RX_WORD_READ ##1 RX_WORD_OFFSET != 3'h0);
    c_halt: cover property (stop_done && !wr_tx);

endmodule // fifo_tx_rx_config_control

`default_nettype wire

// ==== fifo_cfg_pkg.sv ====
/*
 * Package for the FIFO receive/transmit configuration register bank.
 * Holds register byte addresses, field positions, reset values, the end
 * alignment codes and the packed structs that carry the configuration.
 * Assumes a 32-bit APB register bus with one aligned word per register.
 */
package fifo_cfg_pkg;

    // Register byte addresses.
    localparam logic [7:0] RX_CFG_ADDR       = 8'h6C;
    localparam logic [7:0] TX_CFG_ADDR       = 8'h70;

    // Receive configuration field positions.
    localparam int RX_ALIGN_HI  = 31;
    localparam int RX_ALIGN_LO  = 30;
    localparam int RX_FLUSH_BIT = 15;
    localparam int RX_OFF_HI    = 12;
    localparam int RX_OFF_LO    = 8;

    // Transmit configuration field positions.
    localparam int TXS_FLUSH_BIT = 15;
    localparam int TXD_FLUSH_BIT = 14;
    localparam int TX_ALLOW_BIT  = 2;
    localparam int TX_ON_BIT     = 1;
    localparam int TX_STOP_BIT   = 0;

    // End alignment codes.
    localparam logic [1:0] ALIGN_4B  = 2'h0;
    localparam logic [1:0] ALIGN_16B = 2'h1;
    localparam logic [1:0] ALIGN_32B = 2'h2;

    // Pad masks, in words minus one, for each alignment.
    localparam logic [2:0] PAD_MASK_4B  = 3'h0;
    localparam logic [2:0] PAD_MASK_16B = 3'h3;
    localparam logic [2:0] PAD_MASK_32B = 3'h7;

    // Reset values.
    localparam logic [1:0] RX_ALIGN_RST = 2'h0;
    localparam logic [4:0] RX_OFF_RST   = 5'h00;

    // Receive configuration as stored.
    typedef struct packed {
        logic [1:0] align;
        logic       flush;
        logic [4:0] byte_offset;
    } rx_cfg_t;

    // Transmit configuration as stored.
    typedef struct packed {
        logic status_flush;
        logic data_flush;
        logic allow_overrun;
        logic tx_on;
        logic stop_req;
    } tx_cfg_t;

endpackage

// ==== fifo_tx_rx_config_control_bench.sv ====
/*
 * Self-checking bench for the FIFO receive/transmit configuration bank.
 * Assumes the design answers each APB access with PREADY one cycle after
 * setup, and that the engine strobes are driven here on CLOCK edges.
 */
`timescale 1ns/1ps
`default_nettype none

module fifo_tx_rx_config_control_bench
    import fifo_cfg_pkg::*;
;
    logic        clock;
    logic        rstn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        halted;
    logic        full;
    logic        wrd;
    logic        pkt;
    logic        last;
    logic        rxc;
    logic        txsc;
    logic        txdc;
    logic [1:0]  boff;
    logic [2:0]  woff;
    logic [1:0]  align;
    logic [2:0]  pad;
    logic        padv;
    logic        txen;
    logic        stop;
    logic        susp;
    logic        evt;
    int          n_fail;
    int          cmp_count;

    fifo_tx_rx_config_control fifo_tx_rx_config_control_i (
        .CLOCK(clock), .RSTN(rstn), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .TX_HALTED(halted), .TX_STATUS_FULL(full),
        .RX_WORD_READ(wrd), .RX_PKT_START(pkt), .RX_LAST_READ(last),
        .RX_FIFO_CLEAR(rxc), .TXS_FIFO_CLEAR(txsc), .TXD_FIFO_CLEAR(txdc),
        .RX_BYTE_OFFSET(boff), .RX_WORD_OFFSET(woff), .RX_END_ALIGN(align),
        .RX_PAD_WORDS(pad), .RX_PAD_VALID(padv), .TX_ENABLE(txen),
        .TX_STOP_REQ(stop), .TX_SUSPEND(susp), .TSF_FULL_EVT(evt));

    // Free-running 10 MHz clock.
    always #50 clock = ~clock;

    // Prints the counts and the verdict, then ends the run.
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Compares a seen value against the expected one.
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // One APB transfer; the request is held until PREADY is seen high.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clock);
        penable <= 1'b1;
        // Answer and data are taken at the very rising edge that shows PREADY high.
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) begin
            n_fail++;
            give_verdict();
        end else begin
            rd = prdata;
            err = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask

    // Register write, ignoring the answer.
    task automatic wreg(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask

    // Register read with data and error checked.
    task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] exp,
                        input logic expe);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0, r, e);
        chk(nm, r, exp);
        chk("pslverr", {31'h0, e}, {31'h0, expe});
    endtask

    // Reset values, an unmapped access, and the offset split.
    task automatic t_offset();
        rchk("rx_cfg rst", RX_CFG_ADDR, 32'h0, 1'b0);
        rchk("tx_cfg rst", TX_CFG_ADDR, 32'h0, 1'b0);
        rchk("unmapped", 8'h74, 32'h0, 1'b1);
        wreg(RX_CFG_ADDR, 32'h80001F00);
        @(negedge clock);
        chk("byte off", {30'h0, boff}, 32'h3);
        chk("align", {30'h0, align}, 32'h2);
        chk("word off early", {29'h0, woff}, 32'h0);
        rchk("rx_cfg", RX_CFG_ADDR, 32'h80001F00, 1'b0);
        @(posedge clock);
        wrd <= 1'b1;
        @(posedge clock);
        wrd <= 1'b0;
        @(negedge clock);
        chk("word off", {29'h0, woff}, 32'h7);
    endtask

    // Two-word buffer under every alignment code, reserved one included.
    task automatic t_pad();
        logic [2:0] m;
        for (int c = 0; c < 4; c++) begin
            wreg(RX_CFG_ADDR, {c[1:0], 30'h0});
            // Two words read: 16-byte lines need two filler words, 32-byte lines six.
            m = (c == 1) ? 3'h2 : (c == 2) ? 3'h6 : 3'h0;
            @(posedge clock);
            pkt <= 1'b1;
            @(posedge clock);
            pkt <= 1'b0;
            wrd <= 1'b1;
            @(posedge clock);
            last <= 1'b1;
            @(posedge clock);
            wrd <= 1'b0;
            last <= 1'b0;
            @(negedge clock);
            chk("pad valid", {31'h0, padv}, 32'h1);
            chk("pad words", {29'h0, pad}, {29'h0, m});
            @(negedge clock);
            chk("pad valid end", {31'h0, padv}, 32'h0);
        end
    endtask

    // Each flush bit gives one clear pulse and then reads back zero.
    task automatic t_flush();
        for (int i = 0; i < 3; i++) begin
            wreg((i == 0) ? RX_CFG_ADDR : TX_CFG_ADDR, (i == 2) ? 32'h4000 : 32'h8000);
            @(negedge clock);
            chk("clear", {29'h0, rxc, txsc, txdc}, {29'h0, 3'h4 >> i});
            @(negedge clock);
            chk("clear end", {29'h0, rxc, txsc, txdc}, 32'h0);
            rchk("flush rd", (i == 0) ? RX_CFG_ADDR : TX_CFG_ADDR, 32'h0, 1'b0);
        end
    endtask

    // Full status FIFO suspends only without overrun permission.
    task automatic t_suspend();
        wreg(TX_CFG_ADDR, 32'h2);
        @(negedge clock);
        chk("tx on", {31'h0, txen}, 32'h1);
        @(posedge clock);
        full <= 1'b1;
        repeat (3) @(negedge clock);
        chk("suspend", {31'h0, susp}, 32'h1);
        chk("full evt", {31'h0, evt}, 32'h1);
        wreg(TX_CFG_ADDR, 32'h6);
        repeat (3) @(negedge clock);
        chk("no suspend", {31'h0, susp}, 32'h0);
        chk("full evt ovr", {31'h0, evt}, 32'h1);
        @(posedge clock);
        full <= 1'b0;
    endtask

    // Stop request ignores writes while high and clears on halt.
    task automatic t_stop();
        wreg(TX_CFG_ADDR, 32'h3);
        @(negedge clock);
        chk("stop", {30'h0, stop, txen}, 32'h3);
        wreg(TX_CFG_ADDR, 32'h0);
        rchk("stop held", TX_CFG_ADDR, 32'h1, 1'b0);
        wreg(TX_CFG_ADDR, 32'h2);
        @(posedge clock);
        halted <= 1'b1;
        @(posedge clock);
        halted <= 1'b0;
        @(negedge clock);
        chk("halt clears", {30'h0, stop, txen}, 32'h0);
        rchk("tx_cfg halted", TX_CFG_ADDR, 32'h0, 1'b0);
    endtask

    // Reset, then the scenarios in turn.
    initial begin
        clock = 1'b0;
        rstn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {halted, full, wrd, pkt, last} = '0;
        n_fail = 0;
        cmp_count = 0;
        repeat (5) @(posedge clock);
        rstn <= 1'b1;
        t_offset();
        t_pad();
        t_flush();
        t_suspend();
        t_stop();
        give_verdict();
    end

    // Watchdog well beyond the hundred or so cycles the scenarios take.
    initial begin
        #2000000;
        n_fail++;
        give_verdict();
    end

endmodule // fifo_tx_rx_config_control_bench

`default_nettype wire
